//--- hw/fsp_seq.sv
// Purpose: Self-programming sequencer for paged program flash.
// Assumes: Core strobes are one cycle long and synchronous to clk.
// Notes: Lock bits are held in flops here; fuses arrive as programmed flags.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "fsp_defines.svh"

// Contract
// - Erase command then store within four cycles erases page, data ignored.
// - Erase of concurrent section keeps halting section readable; else halt core.
// - Load command then store writes data pair at pointer word field.
// - Buffer clears after page write, on reenable write, on reset.
// - EEPROM write during buffer loading discards loaded data.
// - Write command then store programs buffer into the page, data ignored.
// - Write to halting section halts core; concurrent section write does not.
// - Ready interrupt stays asserted while enabled and instruction enable clear.
// - Erase or write blocks concurrent section reads and holds busy flag; busy flag is set here only for concurrent section pages.
// - Lock command then store sets boot lock bits from low data.
// - Program lock bits whose low data bits 5:2 are zero; pointer ignored.
// - Lock programming keeps all flash readable, no halt; a busy flag left set still blocks concurrent section reads here.
// - EEPROM write busy refuses commands and fuse or lock readback.
// - Pointer 0001 with readback armed, load within three cycles returns locks.
// - Readback bits clear after readback or three or four cycle expiry.
// - Pointer 0000 readback returns low fuse byte bit 7 down to 0.
// - Pointer 0003 readback returns high fuse byte.
// - Readback shows programmed bits as zero, unprogrammed as one.
// - Buffer words load in any order; software erases same page first.
// - Instruction enable stays set for whole erase or write.
// - Erase, write and lock programming last between 3.7 and 4.5 ms.
// - Reenable write during loading aborts load and discards buffer.
// - Instruction enable arms store for four cycles, then clears.
module fsp_seq
  import fsp_pkg::*;
#(
  parameter int PAGE_WORDS = 64,
  parameter int NUM_PAGES = 128,
  parameter int HALT_FIRST_PAGE = 112,
  parameter int OP_CYCLES = `FSP_OP_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // Core instruction port.
  input wire fsp_core_req_t core_req,
  output logic lpm_ack,
  output logic [7:0] lpm_data,
  output logic cpu_halt,
  output logic rww_read_block,
  output logic spm_ready_irq,
  // EEPROM status.
  input wire logic eeprom_write_busy_flag,
  input wire logic eeprom_write_start,
  // Fuses, one bit per fuse, high when programmed.
  input wire logic [7:0] fuse_low_byte,
  input wire logic [7:0] fuse_high_byte,
  // Flash array side.
  output fsp_flash_cmd_t flash_cmd,
  output logic [3:0] boot_lock_prog,
  input wire logic [$clog2(PAGE_WORDS)-1:0] flash_buf_addr,
  output logic [15:0] flash_buf_data
);
  localparam int WB = $clog2(PAGE_WORDS);
  localparam int PB = $clog2(NUM_PAGES);

  if ((1 << WB) != PAGE_WORDS || (1 << PB) != NUM_PAGES || WB + PB + 1 > 16 ||
      HALT_FIRST_PAGE > NUM_PAGES || OP_CYCLES < 2) begin : g_bad_params
    $error("fsp_seq: unsupported parameter values");
  end

  // Flops.
  fsp_state_t st_q, st_d;
  fsp_op_t op_q, op_d;
  logic [4:0] cmd_q, cmd_d;
  logic ie_q, ie_d;
  logic [2:0] cnt_q, cnt_d;
  logic [31:0] tmr_q, tmr_d;
  logic [PB-1:0] page_q, page_d;
  logic halt_q, halt_d;
  logic busy_q, busy_d;
  logic [3:0] lock_q, lock_d;
  logic [3:0] lock_pend_q, lock_pend_d;
  logic [PAGE_WORDS-1:0] vld_q, vld_d;
  logic [15:0] buf_mem [PAGE_WORDS];
  logic [7:0] rdata_q;
  logic ack_q;
  logic [7:0] lpm_q;
  logic [15:0] bufq_q;
  logic start_q;

  // Decode.
  wire ctrl_hit = (reg_addr == `FSP_CTRL_OFS);
  wire ctrl_wr = reg_we && ctrl_hit;
  wire [4:0] wcmd = reg_wdata[4:0];
  wire cmd_legal = (wcmd == `FSP_CMD_LOAD) || (wcmd == `FSP_CMD_ERASE) ||
                   (wcmd == `FSP_CMD_WRITE) || (wcmd == `FSP_CMD_LOCK) ||
                   (wcmd == `FSP_CMD_REEN);
  wire idle = (st_q == ST_IDLE);
  wire cmd_take = ctrl_wr && cmd_legal && idle && !eeprom_write_busy_flag;
  wire armed = (cnt_q != 3'h0);
  wire spm_go = core_req.spm && armed && cmd_q[`FSP_B_EN] && idle &&
                !eeprom_write_busy_flag;
  wire lpm_go = core_req.lpm && (cnt_q >= `FSP_LOAD_MIN_CNT) &&
                (cmd_q == `FSP_CMD_LOCK) && idle && !eeprom_write_busy_flag;
  wire [WB-1:0] z_word = core_req.z[WB:1];
  wire [PB-1:0] z_page = core_req.z[WB+PB:WB+1];
  wire z_halting = (32'(z_page) >= HALT_FIRST_PAGE);
  wire is_load = spm_go && (cmd_q == `FSP_CMD_LOAD);
  wire is_erase = spm_go && (cmd_q == `FSP_CMD_ERASE);
  wire is_write = spm_go && (cmd_q == `FSP_CMD_WRITE);
  wire is_lock = spm_go && (cmd_q == `FSP_CMD_LOCK);
  wire is_reen = spm_go && (cmd_q == `FSP_CMD_REEN);
  wire done = (st_q == ST_BUSY) && (tmr_q == 32'h0000_0000);
  wire loading = (vld_q != '0);
  // Reenable written with enable aborts any load in progress.
  wire reen_wr = cmd_take && (wcmd == `FSP_CMD_REEN);
  wire buf_clr = reen_wr || (done && op_q == OP_WRITE) ||
                 (eeprom_write_start && loading);
  wire [PAGE_WORDS-1:0] set_mask = is_load ? (PAGE_WORDS'(1) << z_word) : '0;
  wire [7:0] lock_byte = {2'b11, ~lock_q, 2'b11};

  function automatic logic [7:0] readback(input logic [15:0] z, input logic [7:0] lk,
                                          input logic [7:0] flo, input logic [7:0] fhi);
    logic [7:0] r;
    r = `FSP_UNKNOWN_BYTE;
    if (z == `FSP_Z_FUSE_LO) begin
      r = ~flo;
    end else if (z == `FSP_Z_LOCK) begin
      r = lk;
    end else if (z == `FSP_Z_FUSE_HI) begin
      r = ~fhi;
    end
    return r;
  endfunction : readback

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    cmd_d = cmd_q;
    ie_d = ie_q;
    cnt_d = armed ? cnt_q - 3'h1 : 3'h0;
    tmr_d = tmr_q;
    page_d = page_q;
    halt_d = halt_q;
    busy_d = busy_q;
    lock_d = lock_q;
    lock_pend_d = lock_pend_q;
    // Set wins over clear so a word stored on a clearing cycle survives.
    vld_d = (buf_clr ? '0 : vld_q) | set_mask;
    if (ctrl_wr) begin
      ie_d = reg_wdata[`FSP_B_IE];
    end
    if (cmd_take) begin
      cmd_d = wcmd;
      cnt_d = `FSP_STORE_WIN;
    end else if (lpm_go) begin
      cmd_d = 5'h00;
      cnt_d = 3'h0;
    end else if (is_load || is_reen) begin
      cmd_d = 5'h00;
      cnt_d = 3'h0;
      busy_d = 1'b0;
    end else if (is_erase || is_write) begin
      st_d = ST_BUSY;
      op_d = is_erase ? OP_ERASE : OP_WRITE;
      page_d = z_page;
      halt_d = z_halting;
      busy_d = busy_q || !z_halting;
      tmr_d = 32'(OP_CYCLES - 1);
      cnt_d = 3'h0;
    end else if (is_lock) begin
      st_d = ST_BUSY;
      op_d = OP_LOCK;
      halt_d = 1'b0;
      lock_pend_d = ~core_req.data[`FSP_LOCK_MSB:`FSP_LOCK_LSB];
      tmr_d = 32'(OP_CYCLES - 1);
      cnt_d = 3'h0;
    end else if (idle && cnt_q == 3'h1) begin
      cmd_d = 5'h00;
    end
    if (st_q == ST_BUSY) begin
      tmr_d = tmr_q - 32'h0000_0001;
      if (done) begin
        st_d = ST_IDLE;
        op_d = OP_NONE;
        cmd_d = 5'h00;
        halt_d = 1'b0;
        tmr_d = 32'h0000_0000;
        if (op_q == OP_LOCK) begin
          lock_d = lock_q | lock_pend_q;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      op_q <= OP_NONE;
      cmd_q <= 5'h00;
      ie_q <= 1'b0;
      cnt_q <= 3'h0;
      tmr_q <= 32'h0000_0000;
      page_q <= '0;
      halt_q <= 1'b0;
      busy_q <= 1'b0;
      lock_q <= 4'h0;
      lock_pend_q <= 4'h0;
      vld_q <= '0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      cmd_q <= cmd_d;
      ie_q <= ie_d;
      cnt_q <= cnt_d;
      tmr_q <= tmr_d;
      page_q <= page_d;
      halt_q <= halt_d;
      busy_q <= busy_d;
      lock_q <= lock_d;
      lock_pend_q <= lock_pend_d;
      vld_q <= vld_d;
    end
  end

  // The buffer array carries no reset; the valid vector stands for its contents.
  always_ff @(posedge clk) begin
    if (is_load) begin
      buf_mem[z_word] <= core_req.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
      lpm_q <= 8'h00;
      bufq_q <= `FSP_ERASED_WORD;
      start_q <= 1'b0;
    end else begin
      rdata_q <= (reg_re && ctrl_hit) ?
                 {ie_q, busy_q, 1'b0, cmd_q} : 8'h00;
      ack_q <= lpm_go;
      lpm_q <= lpm_go ? readback(core_req.z, lock_byte, fuse_low_byte, fuse_high_byte) : lpm_q;
      bufq_q <= vld_q[flash_buf_addr] ? buf_mem[flash_buf_addr] : `FSP_ERASED_WORD;
      start_q <= is_erase || is_write || is_lock;
    end
  end

  assign reg_rdata = rdata_q;
  assign lpm_ack = ack_q;
  assign lpm_data = lpm_q;
  assign cpu_halt = halt_q;
  assign rww_read_block = busy_q || (st_q == ST_BUSY && op_q != OP_LOCK);
  assign spm_ready_irq = ie_q && !cmd_q[`FSP_B_EN];
  assign flash_cmd.start = start_q;
  assign flash_cmd.active = (st_q == ST_BUSY);
  assign flash_cmd.op = op_q;
  assign flash_cmd.page = 16'(page_q);
  assign boot_lock_prog = lock_q;
  assign flash_buf_data = bufq_q;

  // Helper counter of active cycles for the duration check.
  logic [31:0] len_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      len_q <= 32'h0000_0000;
    end else begin
      len_q <= flash_cmd.active ? len_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  arm_expiry_a: assert property (@(posedge clk) disable iff (!rst_n)
    (idle && cnt_q == 3'h1 && !spm_go && !lpm_go && !cmd_take) |=> (cmd_q == 5'h00))
    else $error("armed command not cleared at window end");
  late_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    (idle && !armed && !cmd_take) ##1 core_req.spm |=> (st_q == ST_IDLE))
    else $error("store after expiry started an operation");
  ready_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ie_q && idle && !armed) |-> spm_ready_irq)
    else $error("ready interrupt missing");
  busy_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == ST_BUSY) |-> cmd_q[`FSP_B_EN])
    else $error("enable dropped during operation");
  op_length_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(flash_cmd.active) |-> ($past(len_q) == 32'(OP_CYCLES - 1)))
    else $error("operation length wrong");
  halt_section_a: assert property (@(posedge clk) disable iff (!rst_n)
    (is_erase || is_write) |=> (cpu_halt == $past(z_halting)))
    else $error("halt does not follow target section");
  lock_no_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
    (op_q == OP_LOCK) |-> (!cpu_halt && !rww_read_block) || busy_q)
    else $error("lock programming blocked reads");
  rww_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == ST_BUSY && (op_q == OP_ERASE || op_q == OP_WRITE) && !halt_q) |->
    (rww_read_block && busy_q))
    else $error("concurrent section not blocked");
  eeprom_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (eeprom_write_busy_flag && core_req.lpm) |=> !lpm_ack)
    else $error("readback during eeprom write");
  buf_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (done && op_q == OP_WRITE && !is_load) |=> (vld_q == '0))
    else $error("buffer not cleared after page write");
  fuse_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (lpm_go && core_req.z == `FSP_Z_FUSE_LO) |=> (lpm_data == ~$past(fuse_low_byte)))
    else $error("low fuse readback wrong");
  // Start of each operation and what it latches on the accepting store.
  erase_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_erase |=>
    (flash_cmd.start && flash_cmd.active && flash_cmd.op == OP_ERASE))
    else $error("page erase did not start");
  write_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_write |=>
    (flash_cmd.start && flash_cmd.active && flash_cmd.op == OP_WRITE))
    else $error("page write did not start");
  page_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (is_erase || is_write) |=>
    (flash_cmd.page == 16'($past(z_page))))
    else $error("page address not latched");
  lock_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_lock |=>
    (flash_cmd.start && flash_cmd.op == OP_LOCK && !cpu_halt))
    else $error("lock programming did not start");
  lock_apply_a: assert property (@(posedge clk) disable iff (!rst_n)
    (done && op_q == OP_LOCK) |=>
    (boot_lock_prog == ($past(lock_q) | $past(lock_pend_q))))
    else $error("lock bits not applied");
  // Buffer loading and the events that discard it.
  load_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_load |=>
    (vld_q[$past(z_word)] && buf_mem[$past(z_word)] == $past(core_req.data)))
    else $error("buffer word not stored");
  reen_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reen_wr && !is_load) |=>
    (vld_q == '0))
    else $error("reenable did not discard buffer");
  eeprom_discard_a: assert property (@(posedge clk) disable iff (!rst_n)
    (eeprom_write_start && loading && !is_load) |=>
    (vld_q == '0))
    else $error("eeprom write did not discard buffer");
  busy_reen_a: assert property (@(posedge clk) disable iff (!rst_n)
    (is_reen || is_load) |=>
    !busy_q)
    else $error("section busy not cleared");
  // Arming windows, readback and refusal.
  arm_window_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_take |=>
    (cnt_q == `FSP_STORE_WIN && cmd_q == $past(wcmd)))
    else $error("arming window not opened");
  late_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    (core_req.lpm && idle && cnt_q < `FSP_LOAD_MIN_CNT) |=>
    !lpm_ack)
    else $error("readback accepted outside window");
  readback_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (lpm_go && !cmd_take) |=>
    (lpm_ack && cmd_q == 5'h00))
    else $error("readback did not disarm");
  lock_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (lpm_go && core_req.z == `FSP_Z_LOCK) |=>
    (lpm_data == {2'b11, ~$past(lock_q), 2'b11}))
    else $error("lock readback wrong");
  fuse_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    (lpm_go && core_req.z == `FSP_Z_FUSE_HI) |=>
    (lpm_data == ~$past(fuse_high_byte)))
    else $error("high fuse readback wrong");
  eeprom_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    (eeprom_write_busy_flag && core_req.spm) |=>
    !flash_cmd.start)
    else $error("store accepted during eeprom write");
  enable_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(flash_cmd.active) |->
    (cmd_q == 5'h00 && st_q == ST_IDLE && (spm_ready_irq || !ie_q)))
    else $error("enable not cleared at operation end");
endmodule : fsp_seq

//--- hw/fsp_defines.svh
// Purpose: Constants for the flash self-programming sequencer.
// Assumes: 20 MHz core clock.
// Notes: Offsets, bit positions, command codes and timing counts.
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
`define FSP_CTRL_OFS 8'h00
`define FSP_CTRL_RST 8'h00
`define FSP_B_EN 0
`define FSP_B_IE 7
`define FSP_B_BUSY 6
`define FSP_CMD_LOAD 5'h01
`define FSP_CMD_ERASE 5'h03
`define FSP_CMD_WRITE 5'h05
`define FSP_CMD_LOCK 5'h09
`define FSP_CMD_REEN 5'h11
`define FSP_STORE_WIN 3'h4
`define FSP_LOAD_MIN_CNT 3'h2
`define FSP_CLK_NS 50
`define FSP_T_OP_MIN_NS 3700000
`define FSP_T_OP_MAX_NS 4500000
`define FSP_OP_CYC ((`FSP_T_OP_MIN_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_Z_FUSE_LO 16'h0000
`define FSP_Z_LOCK 16'h0001
`define FSP_Z_FUSE_HI 16'h0003
`define FSP_LOCK_LSB 2
`define FSP_LOCK_MSB 5
`define FSP_ERASED_WORD 16'hFFFF
`define FSP_UNKNOWN_BYTE 8'hFF
`endif

//--- hw/fsp_pkg.sv
// Purpose: Types shared by the flash self-programming sequencer.
// Assumes: Nothing beyond the defines header.
// Notes: Core requests and flash commands travel as packed structs.
package fsp_pkg;
  typedef enum logic [0:0] {ST_IDLE, ST_BUSY} fsp_state_t;
  typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_WRITE, OP_LOCK} fsp_op_t;
  typedef struct packed {
    logic spm;
    logic lpm;
    logic [15:0] z;
    logic [15:0] data;
  } fsp_core_req_t;
  typedef struct packed {
    logic start;
    logic active;
    fsp_op_t op;
    logic [15:0] page;
  } fsp_flash_cmd_t;
endpackage : fsp_pkg

//--- dv/fsp_core_model.sv
// Purpose: Core model that writes the control register, then stores or loads.
// Assumes: Register reads answer in the cycle after the read strobe.
// Notes: Released pointer and data lines show inverted values, not stale ones.
`timescale 1ns/1ps
module fsp_core_model
  import fsp_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Register port.
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  output logic reg_re,
  input wire logic [7:0] reg_rdata,
  // Core instruction port.
  output fsp_core_req_t core_req
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    core_req = '0;
  end
  // The instruction follows dly cycles after the write; dly above four is a late store, above three a late load.
  task automatic op(input logic [7:0] code, input logic [15:0] z, input logic [15:0] d,
      input int dly, input bit ld);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_wdata <= code;
    @(posedge clk);
    reg_we <= 1'b0;
    reg_wdata <= ~code;
    repeat (dly - 1) @(posedge clk);
    core_req <= '{spm: !ld, lpm: ld, z: z, data: d};
    @(posedge clk);
    core_req <= '{spm: 1'b0, lpm: 1'b0, z: ~z, data: ~d};
  endtask : op
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    reg_addr <= 8'h00;
    #1 q = reg_rdata;
  endtask : rd
endmodule : fsp_core_model

//--- dv/tb.sv
// Purpose: Self-checking bench for the flash self-programming sequencer.
// Assumes: Eight-word pages, sixteen pages, pages 14 and 15 halt the core.
// Notes: A scoreboard of buffer words, lock bits and busy flag gives expectations.
`timescale 1ns/1ps
module tb;
  import fsp_pkg::*;
  localparam int OPC = 20;
  logic clk, rst_n, reg_we, reg_re, lpm_ack, cpu_halt, rww_read_block, spm_ready_irq;
  logic eeprom_write_busy_flag, eeprom_write_start;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lpm_data, fuse_low_byte, fuse_high_byte, q;
  logic [3:0] boot_lock_prog;
  logic [2:0] flash_buf_addr;
  logic [15:0] flash_buf_data, d;
  logic [31:0] lfsr_q = 32'h0000_42d0;
  fsp_core_req_t core_req;
  fsp_flash_cmd_t flash_cmd;
  int miscompares, num_checks, bsy_m, lock_m;
  int buf_m[8];
  fsp_seq #(.PAGE_WORDS(8), .NUM_PAGES(16), .HALT_FIRST_PAGE(14), .OP_CYCLES(OPC)) fsp_seq_inst (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .core_req, .lpm_ack,
    .lpm_data, .cpu_halt, .rww_read_block, .spm_ready_irq, .eeprom_write_busy_flag,
    .eeprom_write_start, .fuse_low_byte, .fuse_high_byte, .flash_cmd, .boot_lock_prog,
    .flash_buf_addr, .flash_buf_data);
  fsp_core_model fsp_core_model_inst (.clk, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .core_req);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [15:0] rnd();
    repeat (16) lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[15:0];
  endfunction : rnd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic bchk(input int w);
    @(posedge clk);
    flash_buf_addr <= 3'(w);
    @(posedge clk);
    #1 chk(flash_buf_data, buf_m[w] < 0 ? 16'hFFFF : 16'(buf_m[w]), "buffer");
  endtask : bchk
  task automatic load(input int w, input int dly);
    d = rnd();
    fsp_core_model_inst.op(8'h81, 16'(w << 1), d, dly, 1'b0);
    buf_m[w] = d;
    bsy_m = 0;
  endtask : load
  task automatic opchk(input logic [7:0] code, input logic [15:0] z, input logic [15:0] dat,
      input fsp_op_t o);
    logic lk;
    lk = (o == OP_LOCK);
    fsp_core_model_inst.op(code, z, dat, 1, 1'b0);
    if (!lk && z[7:4] < 14) bsy_m = 1;
    #1 chk({flash_cmd.start, flash_cmd.active, flash_cmd.op}, {2'b11, o}, "start");
    if (!lk) chk(flash_cmd.page, 16'(z[7:4]), "page");
    chk({cpu_halt, rww_read_block, spm_ready_irq}, {!lk && z[7:4] >= 14, !lk, 1'b0},
      "halt block");
    fsp_core_model_inst.rd(8'h00, q);
    chk(q, {1'b1, 1'(bsy_m), 1'b0, code[4:0]}, "ctrl in op");
    repeat (OPC - 3) @(posedge clk);
    #1 chk(flash_cmd.active, 1'b1, "held");
    @(posedge clk);
    #1 chk({flash_cmd.active, spm_ready_irq}, 2'b01, "end");
  endtask : opchk
  initial begin
    rst_n = 1'b0;
    eeprom_write_busy_flag = 1'b0;
    eeprom_write_start = 1'b0;
    flash_buf_addr = 3'h0;
    fuse_low_byte = 8'(rnd());
    fuse_high_byte = 8'(rnd());
    miscompares = 0;
    num_checks = 0;
    bsy_m = 0;
    lock_m = 0;
    foreach (buf_m[i]) buf_m[i] = -1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    fsp_core_model_inst.rd(8'h00, q);
    chk({q, spm_ready_irq}, 9'h000, "reset");
    fsp_core_model_inst.rd(8'h55, q);
    chk(q, 8'h00, "unmapped");
    for (int i = 0; i < 8; i++) load(i * 3 % 8, i % 4 + 1);
    for (int i = 0; i < 8; i++) bchk(i);
    opchk(8'h83, 16'h0030, rnd(), OP_ERASE);
    opchk(8'h85, 16'h0030, rnd(), OP_WRITE);
    foreach (buf_m[i]) buf_m[i] = -1;
    bchk(5);
    fsp_core_model_inst.op(8'h91, 16'h0000, 16'h0000, 1, 1'b0);
    bsy_m = 0;
    fsp_core_model_inst.rd(8'h00, q);
    chk(q[6], 1'b0, "busy cleared");
    opchk(8'h83, 16'h00F0, rnd(), OP_ERASE);
    opchk(8'h85, 16'h00F0, rnd(), OP_WRITE);
    load(2, 1);
    load(6, 4);
    @(posedge clk);
    eeprom_write_start <= 1'b1;
    @(posedge clk);
    eeprom_write_start <= 1'b0;
    foreach (buf_m[i]) buf_m[i] = -1;
    bchk(2);
    bchk(6);
    load(1, 2);
    fsp_core_model_inst.op(8'h91, 16'h0000, 16'h0000, 1, 1'b0);
    buf_m[1] = -1;
    bchk(1);
    d = rnd();
    opchk(8'h89, 16'h0001, d, OP_LOCK);
    lock_m = lock_m | int'(~d[5:2]);
    @(posedge clk);
    #1 chk(boot_lock_prog, 4'(lock_m), "lock bits");
    for (int i = 0; i < 3; i++) begin
      fsp_core_model_inst.op(8'h89, 16'(i == 0 ? 0 : 2 * i - 1), 16'h0000, i + 1, 1'b1);
      q = i == 0 ? ~fuse_low_byte : (i == 2 ? ~fuse_high_byte : {2'b11, ~4'(lock_m), 2'b11});
      #1 chk({lpm_ack, lpm_data}, {1'b1, q}, "readback");
    end
    fsp_core_model_inst.rd(8'h00, q);
    chk(q[4:0], 5'h00, "readback cleared");
    @(posedge clk);
    eeprom_write_busy_flag <= 1'b1;
    fsp_core_model_inst.op(8'h83, 16'h0030, 16'h0000, 1, 1'b0);
    #1 chk(flash_cmd.start, 1'b0, "refused op");
    fsp_core_model_inst.op(8'h89, 16'h0001, 16'h0000, 1, 1'b1);
    #1 chk(lpm_ack, 1'b0, "refused readback");
    @(posedge clk);
    eeprom_write_busy_flag <= 1'b0;
    fsp_core_model_inst.op(8'h83, 16'h0030, 16'h0000, 5, 1'b0);
    #1 chk(flash_cmd.start, 1'b0, "late store");
    fsp_core_model_inst.op(8'h89, 16'h0001, 16'h0000, 4, 1'b1);
    #1 chk(lpm_ack, 1'b0, "late load");
    fsp_core_model_inst.rd(8'h00, q);
    chk(q, 8'h80, "window expired");
    wrap_up();
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    #200_000;
    miscompares++;
    wrap_up();
  end
endmodule : tb
